// [tb_top.sv]
// self-checking bench: apb tasks drive the timer, compare model closes the period
// assumes zero-wait apb answers and a one-cycle access phase
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, frc, cmp_en, err;
    logic        ext_pin, xtal_in, xtal_out, osc_en, roll, gclr, trig, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] count, cmp_val, cmax;
    logic [3:0]  cyc;
    int          n_mismatch, checks_done, n_roll, n_irq, r0;
    logic [15:0] tbl[9] = '{16'h4142, 16'h5121, 16'h6110, 16'h7108, 16'h0110, 16'hC100,
                            16'h8108, 16'h8508, 16'h8910};
    timer16_control_autotrigger_reset u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .autoconv_trigger(trig), .external_clock_pin(ext_pin),
        .crystal_in_pin(xtal_in), .crystal_out_pin(xtal_out), .crystal_driver_enable(osc_en),
        .count, .rollover_pulse(roll), .gate_toggle_clear(gclr));
    timer16_cmp_model u_cmp (.count, .cmp_val, .cmp_en, .force_trig(frc), .trig, .cmp_irq(irq));
    // 50 mhz clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // pins toggle at two rates so pin and crystal sources give different counts
    always @(posedge pclk)
    begin
        cyc     <= cyc + 4'h1;
        ext_pin <= cyc[2];
        xtal_in <= cyc[1];
        n_roll  <= n_roll + int'(roll);
    end
    // one apb transfer; t raises the trigger in the access cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic t);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        frc     <= t;
        // look at pready mid-cycle, so the edge that takes the transfer is never raced
        @(negedge pclk);
        while (pready !== 1'b1)
            @(negedge pclk);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        frc     <= 1'b0;
        // outputs launched by the access edge are settled before anyone compares them
        @(negedge pclk);
    endtask
    task automatic set_count(input logic [15:0] v);
        xfer(1'b1, timer16_pkg::count_low_addr, {24'h0, v[7:0]}, 1'b0);
        xfer(1'b1, timer16_pkg::count_high_addr, {24'h0, v[15:8]}, 1'b0);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input logic [31:0] lo, hi, g);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
        end
    endtask
    // count 64 cycles with one source setting; tolerance covers sync latency
    task automatic run(input logic [7:0] c, input int e);
        xfer(1'b1, timer16_pkg::ctrl_addr, 32'h0000_0000, 1'b0);
        set_count(16'h0000);
        xfer(1'b1, timer16_pkg::ctrl_addr, {24'h0, c}, 1'b0);
        repeat (64) @(posedge pclk);
        chk("gate clear", 32'h0000_0000, gclr);
        xfer(1'b1, timer16_pkg::ctrl_addr, 32'h0000_0000, 1'b0);
        chk_rng("count", e < 2 ? 0 : e - 2, e + 2, count);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, frc, cmp_en, ext_pin, xtal_in, paddr, pwdata} = '0;
        {cmp_val, cyc, cmax} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, timer16_pkg::ctrl_addr, 32'h0000_0000, 1'b0);
        chk("ctrl reset", 32'h0000_0000, rd);
        chk("gate clear", 32'h0000_0001, gclr);
        xfer(1'b1, timer16_pkg::ctrl_addr, 32'h0000_00FF, 1'b0);
        xfer(1'b0, timer16_pkg::ctrl_addr, 32'h0000_0000, 1'b0);
        chk("ctrl", 32'h0000_00FD, rd);
        chk("osc enable", 32'h0000_0001, osc_en);
        xfer(1'b0, 8'h10, 32'h0000_0000, 1'b0);
        chk("unmapped error", 32'h0000_0001, err);
        foreach (tbl[i]) run(tbl[i][15:8], int'(tbl[i][7:0]));
        set_count(16'hFFFF);
        r0 = n_roll;
        xfer(1'b1, timer16_pkg::ctrl_addr, 32'h0000_0041, 1'b0);
        repeat (4) @(posedge pclk);
        chk("rollover", r0 + 1, n_roll);
        xfer(1'b1, timer16_pkg::ctrl_addr, 32'h0000_0000, 1'b0);
        xfer(1'b0, timer16_pkg::status_addr, 32'h0000_0000, 1'b0);
        chk("rollover flag", 32'h0000_0001, rd);
        xfer(1'b1, timer16_pkg::status_addr, 32'h0000_0001, 1'b0);
        set_count(16'hFFFF);
        r0 = n_roll;
        xfer(1'b0, timer16_pkg::ctrl_addr, 32'h0000_0000, 1'b1);
        repeat (3) @(posedge pclk);
        chk("count cleared", 32'h0000_0000, count);
        chk("rollover", r0, n_roll);
        xfer(1'b0, timer16_pkg::status_addr, 32'h0000_0000, 1'b0);
        chk("rollover flag", 32'h0000_0000, rd);
        set_count(16'h1234);
        xfer(1'b1, timer16_pkg::count_low_addr, 32'h0000_0056, 1'b1);
        chk("count", 32'h0000_1256, count);
        set_count(16'h0000);
        cmp_val <= 16'h0009;
        cmp_en  <= 1'b1;
        xfer(1'b1, timer16_pkg::ctrl_addr, 32'h0000_0001, 1'b0);
        repeat (400)
        begin
            @(posedge pclk);
            n_irq = n_irq + int'(irq);
            cmax = (count > cmax) ? count : cmax;
        end
        chk("count max", 32'h0000_0009, cmax);
        chk_rng("compare irqs", 9, 12, n_irq);
        cmp_en <= 1'b0;
        results();
    end
    // watchdog: the whole run needs about 1200 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        results();
    end
endmodule // tb_top
`default_nettype wire

// [timer16_cmp_model.sv]
// compare unit model on the far side: auto-conversion trigger and own irq
// assumes the bench sets the compare pair and may command a trigger
`default_nettype none
module timer16_cmp_model (
    input  wire logic [15:0] count,      // timer count
    input  wire logic [15:0] cmp_val,    // compare pair value
    input  wire logic        cmp_en,     // compare mode on
    input  wire logic        force_trig, // bench-commanded trigger
    output logic             trig,       // auto-conversion trigger
    output logic             cmp_irq     // compare interrupt
);
    // a match drives the clear, so the compare pair acts as the period
    assign trig = (cmp_en && count == cmp_val) || force_trig;
    // the compare unit keeps raising its own interrupt
    assign cmp_irq = trig;
endmodule // timer16_cmp_model
`default_nettype wire

// [timer16_control_autotrigger_reset.sv]
// 16-bit timer with control register, clock selection and trigger period reset
// assumes an apb master on pclk and a compare unit driving a one-cycle trigger
//
// How it works
// (RULE1) trigger clears whole 16-bit count
// (RULE2) trigger clear never sets rollover flag
// (RULE3) compare unit keeps its own interrupt
// (RULE4) compare value becomes period via clearing
// (RULE5) software should use synced instruction clock
// (RULE6) count write beats coincident trigger clear
// (RULE7) bits 7-6 select clock source
// (RULE8) pin source: pin edge or crystal
// (RULE9) prescale divides by 1,2,4,8
// (RULE10) bit 3 enables crystal oscillator
// (RULE11) bit 2 set bypasses input synchroniser
// (RULE12) bit 0 runs timer; clear stops, clears gate
// (RULE13) bit 1 always reads zero
// (RULE14) prescaler restarts on disable or prescale write; a write restarts it only when the prescale value changes
`default_nettype none
module timer16_control_autotrigger_reset (
    input  wire logic        pclk,                  // system clock, 50 mhz
    input  wire logic        presetn,               // async reset, active low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb access phase
    input  wire logic        pwrite,                // apb direction
    input  wire logic [7:0]  paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error, unmapped address
    output logic [31:0]      prdata,                // apb read data
    input  wire logic        autoconv_trigger,      // compare match, one-cycle pulse
    input  wire logic        external_clock_pin,    // external count clock
    input  wire logic        crystal_in_pin,        // crystal oscillator input
    output logic             crystal_out_pin,       // crystal drive, inverted input
    output logic             crystal_driver_enable, // oscillator circuit enable
    output logic [15:0]      count,                 // count value to compare unit
    output logic             rollover_pulse,        // one cycle on ffff to 0000
    output logic             gate_toggle_clear      // clears gate flip-flop
);
    timer16_pkg::top_state_t s_r;
    timer16_pkg::top_state_t s_nxt;

    logic       setup;
    logic       access;
    logic       wr_ctrl;
    logic       wr_low;
    logic       wr_high;
    logic       wr_status;
    logic       mapped;
    logic [1:0] cs;
    logic [1:0] ps;
    logic       on;
    logic       osc_en;
    logic       bypass_sync;
    logic       pin_level;
    logic       pin_edge;
    logic       src_tick;
    logic       psc_clear;
    logic       inc;

    // decode of the address map, used only for the pslverr answer on reads and writes
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == timer16_pkg::ctrl_addr) || (a == timer16_pkg::count_low_addr)
                 || (a == timer16_pkg::count_high_addr) || (a == timer16_pkg::status_addr);
    endfunction

    // control field views
    assign cs          = s_r.ctrl[timer16_pkg::cs_lsb +: 2];
    assign ps          = s_r.ctrl[timer16_pkg::ps_lsb +: 2];
    assign on          = s_r.ctrl[timer16_pkg::on_bit];
    assign osc_en      = s_r.ctrl[timer16_pkg::osc_bit];
    assign bypass_sync = s_r.ctrl[timer16_pkg::sync_bit];

    // bus phases; writes land on the access cycle, which always has pready high
    assign setup     = psel && !penable;
    assign access    = psel && penable && s_r.pready;
    assign mapped    = is_mapped(paddr);
    assign wr_ctrl   = access && pwrite && (paddr == timer16_pkg::ctrl_addr);
    assign wr_low    = access && pwrite && (paddr == timer16_pkg::count_low_addr);
    assign wr_high   = access && pwrite && (paddr == timer16_pkg::count_high_addr);
    assign wr_status = access && pwrite && (paddr == timer16_pkg::status_addr);

    // pin or crystal level; the raw sample skips the two-stage synchroniser
    always_comb
    begin
        if (bypass_sync)
            pin_level = s_r.pin_raw;  // RULE11
        else
            pin_level = s_r.pin_s2;  // RULE11
    end
    assign pin_edge = pin_level && !s_r.pin_prev;  // RULE8

    // source selection; the reserved code produces no ticks
    always_comb
    begin
        unique case (cs)  // RULE7
            timer16_pkg::cs_instr:  src_tick = (s_r.instr_div == timer16_pkg::instr_div_last);
            timer16_pkg::cs_system: src_tick = 1'b1;
            timer16_pkg::cs_pin:    src_tick = pin_edge;
            default:                src_tick = 1'b0;
        endcase
    end

    // a control write that changes the prescale, or a stopped timer, restarts the divider phase
    assign psc_clear = !on
        || (wr_ctrl && (pwdata[timer16_pkg::ps_lsb +: 2] != ps));  // RULE14

    timer16_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (psc_clear),
        .sel     (ps),
        .tick    (src_tick && on),
        .inc     (inc)
    );

    // next state of every register in the block
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rollover_pulse = 1'b0;
        s_nxt.instr_div = s_r.instr_div + 2'h1;

        // input sampling; only s2 reads s1
        s_nxt.pin_s1 = osc_en ? crystal_in_pin : external_clock_pin;  // RULE8
        s_nxt.pin_s2 = s_r.pin_s1;
        s_nxt.pin_raw = osc_en ? crystal_in_pin : external_clock_pin;
        s_nxt.pin_prev = pin_level;

        // crystal driver follows its enable bit
        s_nxt.xtal_out = osc_en && !crystal_in_pin;  // RULE10

        // gate flip-flop held clear while the timer is off
        s_nxt.gate_clear = !on;  // RULE12

        // control register; unimplemented bit stays zero
        if (wr_ctrl)
            s_nxt.ctrl = pwdata[7:0] & timer16_pkg::ctrl_wmask;  // RULE13

        // count: software write, then trigger clear, then increment
        if (wr_low || wr_high)
        begin
            if (wr_low)
                s_nxt.count[7:0] = pwdata[7:0];  // RULE6
            if (wr_high)
                s_nxt.count[15:8] = pwdata[7:0];  // RULE6
        end
        else if (autoconv_trigger)
        begin
            // the compare pair then acts as period; compare irq is left to that unit
            s_nxt.count = timer16_pkg::count_reset;  // RULE1 RULE4 RULE3
        end
        else if (on && inc)
        begin
            s_nxt.count = s_r.count + 16'h0001;  // RULE12
            if (s_r.count == timer16_pkg::count_full)
                s_nxt.rollover_pulse = 1'b1;
        end

        // sticky rollover flag, write one to clear; a new rollover wins
        if (wr_status && pwdata[timer16_pkg::rollover_bit])
            s_nxt.rollover_flag = 1'b0;
        if (s_nxt.rollover_pulse)
            s_nxt.rollover_flag = 1'b1;  // RULE2

        // apb: zero wait states, answer prepared in the setup cycle
        s_nxt.pready = setup;
        s_nxt.pslverr = setup && !mapped;
        if (setup && !pwrite)
        begin
            s_nxt.prdata = 32'h0000_0000;
            unique case (paddr)
                timer16_pkg::ctrl_addr:
                    s_nxt.prdata[7:0] = s_r.ctrl & timer16_pkg::ctrl_wmask;  // RULE13
                timer16_pkg::count_low_addr:  s_nxt.prdata[7:0] = s_r.count[7:0];
                timer16_pkg::count_high_addr: s_nxt.prdata[7:0] = s_r.count[15:8];
                timer16_pkg::status_addr:
                    s_nxt.prdata[timer16_pkg::rollover_bit] = s_r.rollover_flag;
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        else if (setup)
        begin
            s_nxt.prdata = 32'h0000_0000;
        end
    end

    // single state register; constants only under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.ctrl <= timer16_pkg::ctrl_reset;
            s_r.count <= timer16_pkg::count_reset;
            s_r.gate_clear <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // every output straight from the state register
    assign pready                = s_r.pready;
    assign pslverr               = s_r.pslverr;
    assign prdata                = s_r.prdata;
    assign crystal_out_pin       = s_r.xtal_out;
    assign crystal_driver_enable = s_r.ctrl[timer16_pkg::osc_bit];  // RULE10
    assign count                 = s_r.count;
    assign rollover_pulse        = s_r.rollover_pulse;
    assign gate_toggle_clear     = s_r.gate_clear;  // RULE12
endmodule // timer16_control_autotrigger_reset
`default_nettype wire

// [timer16_monitor.sv]
// assertions on the timer block's ports
// assumes apb writes land at the access edge with pready high
`default_nettype none
module timer16_monitor (
    input wire logic        pclk,                  // clock
    input wire logic        presetn,               // reset
    input wire logic        psel,                  // select
    input wire logic        penable,               // access
    input wire logic        pwrite,                // write
    input wire logic [7:0]  paddr,                 // address
    input wire logic [31:0] pwdata,                // wdata
    input wire logic        pready,                // ready
    input wire logic        pslverr,               // error
    input wire logic [31:0] prdata,                // rdata
    input wire logic        autoconv_trigger,      // trigger
    input wire logic        external_clock_pin,    // pin
    input wire logic        crystal_in_pin,        // xtal in
    input wire logic        crystal_out_pin,       // xtal out
    input wire logic        crystal_driver_enable, // osc en
    input wire logic [15:0] count,                 // count
    input wire logic        rollover_pulse,        // rollover
    input wire logic        gate_toggle_clear      // gate clear
);
    logic [7:0] ctrl_r;
    wire logic  wacc = psel && penable && pready && pwrite;
    wire logic  cw = wacc && (paddr == timer16_pkg::count_low_addr
                              || paddr == timer16_pkg::count_high_addr);
    // shadow of the control byte, so the checks know the mode
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ctrl_r <= 8'h00;
        else if (wacc && paddr == timer16_pkg::ctrl_addr)
            ctrl_r <= pwdata[7:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_wlow; autoconv_trigger && wacc && paddr == timer16_pkg::count_low_addr; endsequence
    property p_apb; s_setup |=> pready && pslverr == (paddr > timer16_pkg::status_addr); endproperty
    property p_clear; autoconv_trigger && !cw |=> count == 16'h0000; endproperty
    property p_noroll; autoconv_trigger |=> !rollover_pulse; endproperty
    property p_wins; s_wlow |=> count[7:0] == $past(pwdata[7:0]); endproperty
    property p_bit1;
        pready && !pwrite && paddr == timer16_pkg::ctrl_addr
            |-> prdata == {24'h0, ctrl_r & timer16_pkg::ctrl_wmask};
    endproperty
    property p_osc; crystal_driver_enable == ctrl_r[3]; endproperty
    property p_gate; ctrl_r[0] == $past(ctrl_r[0]) |-> gate_toggle_clear == !ctrl_r[0]; endproperty
    property p_stop; !ctrl_r[0] && !$past(ctrl_r[0]) && !cw && !autoconv_trigger |=> $stable(count);
    endproperty
    property p_sys;
        ctrl_r == 8'h41 && $past(ctrl_r) == 8'h41 && $past(ctrl_r, 2) == 8'h41 && !cw
            && !autoconv_trigger |=> count == $past(count) + 16'h0001;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer wrong");
    a_clear: assert property (p_clear) else $error("trigger left count");
    a_noroll: assert property (p_noroll) else $error("rollover on clear");
    a_wins: assert property (p_wins) else $error("write lost to trigger");
    a_bit1: assert property (p_bit1) else $error("control readback wrong");
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    a_gate: assert property (p_gate) else $error("gate clear wrong");
    a_stop: assert property (p_stop) else $error("stopped timer moved");
    a_sys: assert property (p_sys) else $error("system clock count wrong");
endmodule // timer16_monitor
bind timer16_control_autotrigger_reset timer16_monitor u_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .autoconv_trigger, .external_clock_pin,
    .crystal_in_pin, .crystal_out_pin, .crystal_driver_enable, .count, .rollover_pulse,
    .gate_toggle_clear);
`default_nettype wire

// [timer16_pkg.sv]
// constants and state types for the 16-bit timer control and period-reset block
// assumes a 32-bit apb slave at 50 mhz; one word per register
`default_nettype none
package timer16_pkg;
    // register byte addresses
    localparam logic [7:0] ctrl_addr       = 8'h00;
    localparam logic [7:0] count_low_addr  = 8'h04;
    localparam logic [7:0] count_high_addr = 8'h08;
    localparam logic [7:0] status_addr     = 8'h0C;
    // control field positions
    localparam int cs_lsb     = 6;
    localparam int ps_lsb     = 4;
    localparam int osc_bit    = 3;
    localparam int sync_bit   = 2;
    localparam int on_bit     = 0;
    localparam logic [7:0] ctrl_reset   = 8'h00;
    localparam logic [7:0] ctrl_wmask   = 8'hFD;  // bit 1 unimplemented
    localparam int rollover_bit         = 0;
    // clock source codes
    localparam logic [1:0] cs_instr  = 2'h0;
    localparam logic [1:0] cs_system = 2'h1;
    localparam logic [1:0] cs_pin    = 2'h2;
    // instruction clock is a quarter of the oscillator
    localparam logic [1:0] instr_div_last = 2'h3;
    localparam logic [15:0] count_reset   = 16'h0000;
    localparam logic [15:0] count_full    = 16'hFFFF;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] count;
        logic        rollover_flag;
        logic        rollover_pulse;
        logic [1:0]  instr_div;
        logic        pin_s1;
        logic        pin_s2;
        logic        pin_raw;
        logic        pin_prev;
        logic        xtal_out;
        logic        gate_clear;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } top_state_t;

    typedef struct packed {
        logic [2:0] cnt;
    } psc_state_t;
endpackage
`default_nettype wire

// [timer16_prescaler.sv]
// input prescaler: passes one of every 1, 2, 4 or 8 source ticks
// assumes tick is a one-cycle pulse on pclk
`default_nettype none
module timer16_prescaler (
    input  wire logic       pclk,     // system clock
    input  wire logic       presetn,  // async reset, active low
    input  wire logic       clear,    // restart from phase zero
    input  wire logic [1:0] sel,      // prescale code
    input  wire logic       tick,     // selected source tick
    output logic            inc       // counter increment pulse
);
    timer16_pkg::psc_state_t s_r;
    timer16_pkg::psc_state_t s_nxt;
    logic [2:0] last;

    // last phase for the chosen ratio
    always_comb
    begin
        last = 3'((4'h1 << sel) - 4'h1);  // RULE9
        s_nxt = s_r;
        inc = 1'b0;
        if (clear)
        begin
            s_nxt.cnt = 3'h0;  // RULE14
        end
        else if (tick)
        begin
            if (s_r.cnt == last)
            begin
                s_nxt.cnt = 3'h0;
                inc = 1'b1;  // RULE9
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule // timer16_prescaler
`default_nettype wire
